// ==== design/vpf_params.svh ====
// Offsets, field positions, reset values and codes of the packet trailer framer
`ifndef VPF_PARAMS_SVH
`define VPF_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_SID         8'h04
`define OFS_TRL_EN      8'h08
`define OFS_CTX         8'h0C
`define OFS_STATUS      8'h10
`define OFS_MASK        8'h14
`define OFS_INFO        8'h18

// ----------------------------------------------------------------
// Register fields and reset values
// ----------------------------------------------------------------
`define CTRL_EN_BIT     0
`define CTRL_TSI_LSB    4
`define CTRL_TSF_LSB    6
`define TSI_RST         2'h1
`define TSF_RST         2'h1
`define TS_UNSUPPORTED  2'h0
`define CTX_VLD_BIT     7
`define EV_SENT         0
`define EV_PADDED       1
`define EV_DROPPED      2
`define EV_BITS         3

// ----------------------------------------------------------------
// Packet layout
// ----------------------------------------------------------------
`define PKT_TYPE_IF_SID 4'h1
`define HDR_CLASS_ON    1'h1
`define HDR_TRL_ON      1'h1
`define HDR_RSVD_BITS   2'h0
`define RSVD_WORD       32'h0000_0000
`define TRL_ONES        4'hF
`define HDR_WORDS       16'h0007
`define TRL_WORDS       16'h0001
`define HDR_LAST_IDX    3'h6
`define BLK_MASK        16'h0003
`define WORD_BYTES      4'h4

`endif

// ==== design/vpf_pkg.sv ====
// Types shared by the packet trailer framer
package vpf_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FILL,
		ST_FLUSH,
		ST_PAD,
		ST_HDR,
		ST_DATA,
		ST_TRL
	} vpf_state_t;

	typedef struct packed {
		logic [31:0] data;
		logic        last;
		logic        valid;
	} vpf_beat_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} vpf_apb_rsp_t;

	typedef struct packed {
		logic        en;
		logic [1:0]  tsi;
		logic [1:0]  tsf;
		logic [15:0] dest;
		logic [15:0] sid;
		logic [7:0]  trl_en;
		logic        ctx_vld;
		logic [6:0]  ctx_cnt;
		logic [2:0]  status;
		logic [2:0]  mask;
	} vpf_regs_t;

	typedef struct packed {
		vpf_state_t   state;
		vpf_regs_t    regs;
		vpf_apb_rsp_t apb;
		vpf_beat_t    beat;
		logic         irq;
		logic         in_ready;
		logic         trig_m;
		logic         trig_s;
		logic [7:0]   cond_m;
		logic [7:0]   cond_s;
		logic [7:0]   ind;
		logic [7:0]   en_cap;
		logic [15:0]  dest;
		logic [15:0]  sid;
		logic         ctx_vld;
		logic [6:0]   ctx_cnt;
		logic [1:0]   tsi;
		logic [1:0]   tsf;
		logic [31:0]  ts_int;
		logic [63:0]  ts_frac;
		logic [31:0]  acc;
		logic [1:0]   acc_bytes;
		logic         hi_pend;
		logic [31:0]  hi_word;
		logic [3:0]   nbytes;
		logic [3:0]   pad;
		logic [3:0]   last_pad;
		logic [3:0]   pkt_cnt;
		logic [15:0]  wr_addr;
		logic [15:0]  rd_addr;
		logic [15:0]  data_words;
		logic [2:0]   hdr_idx;
		logic         q_ok;
	} vpf_core_t;

endpackage

// ==== design/vpf_block_ram.sv ====
// Simple dual-port packet store with registered read data
`timescale 1ns/1ps
module vpf_block_ram #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 256
) (
	input  wire logic                     ref_clk_i,
	input  wire logic                     we_i,
	input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
	input  wire logic [WIDTH-1:0]         wdata_i,
	input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
	output logic      [WIDTH-1:0]         rdata_o
);

	logic [WIDTH-1:0] mem [DEPTH];

	// No reset on the array so it maps onto block memory
	always_ff @(posedge ref_clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end

endmodule

// ==== design/vita_packet_trailer_framer.sv ====
// Packet framer: header, reserved words, timestamps, padding and trailer
//
// Notes on behaviour
// - Second header word: mask high, stream id low
// - Destination mask steers packet routing output
// - Stream id tags source; same per source
// - Class OUI and class info words reserved
// - Fifth word holds integer-seconds timestamp
// - Sixth, seventh words: fractional seconds high, low
// - Enables 31:24 pair with indicators 19:12
// - Enabled indicator sticky over current packet
// - Trailer bits 23:20 always one
// - Trailer carries associated context packet count
// - Padding field counts pad bytes, 0..15
// - Early trigger end: withhold until block aligned
// - Load pad count, pad block, then send
// - Maximum padding follows source event width
// - Seven header, one trailer, multiple of four
// - First word: IF data with SID, C, T
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "vpf_params.svh"
module vita_packet_trailer_framer #(
	parameter int EVENT_BITS = 32,
	parameter int DATA_WORDS = 256
) (
	input  wire logic                  ref_clk_i,
	input  wire logic                  srst_i,
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [7:0]            paddr_i,
	input  wire logic [31:0]           pwdata_i,
	output logic      [31:0]           prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	input  wire logic                  trig_i,
	input  wire logic [7:0]            cond_i,
	input  wire logic [31:0]           ts_int_i,
	input  wire logic [63:0]           ts_frac_i,
	input  wire logic [EVENT_BITS-1:0] in_data_i,
	input  wire logic                  in_valid_i,
	output logic                       in_ready_o,
	output logic [31:0]                out_data_o,
	output logic                       out_last_o,
	output logic                       out_valid_o,
	input  wire logic                  out_ready_i,
	output logic [15:0]                dest_o,
	output logic                       irq_o
);

	// ----------------------------------------------------------------
	// Parameters and checks
	// ----------------------------------------------------------------
	localparam int          AW       = $clog2(DATA_WORDS);
	localparam int          EB_BYTES = EVENT_BITS / 8;
	localparam logic [15:0] DW16     = 16'(DATA_WORDS);
	localparam logic [3:0]  EB4      = 4'(EB_BYTES);

	if (EVENT_BITS != 16 && EVENT_BITS != 32 && EVENT_BITS != 64) begin : g_bad_event
		$error("EVENT_BITS must be 16, 32 or 64");
	end
	if (DATA_WORDS < 4 || DATA_WORDS % 4 != 0 || DATA_WORDS > 65520 || (1 << AW) != DATA_WORDS) begin : g_bad_words
		$error("DATA_WORDS must be a power of two, at least 4");
	end

	// ----------------------------------------------------------------
	// Header word builder
	// ----------------------------------------------------------------
	function automatic logic [31:0] hdr_word(input logic [2:0] idx, input vpf_pkg::vpf_core_t s);
		logic [15:0] size;
		size = 16'(s.data_words + `HDR_WORDS + `TRL_WORDS);
		case (idx)
			3'h0: hdr_word = {`PKT_TYPE_IF_SID, `HDR_CLASS_ON, `HDR_TRL_ON, `HDR_RSVD_BITS,
				s.tsi, s.tsf, s.pkt_cnt, size};
			3'h1: hdr_word = {s.dest, s.sid};
			3'h2: hdr_word = `RSVD_WORD;
			3'h3: hdr_word = `RSVD_WORD;
			3'h4: hdr_word = s.ts_int;
			3'h5: hdr_word = s.ts_frac[63:32];
			3'h6: hdr_word = s.ts_frac[31:0];
			default: hdr_word = `RSVD_WORD;
		endcase
	endfunction

	// Enables and indicators sit in matching order, calibrated time first
	function automatic logic [31:0] trl_word(input vpf_pkg::vpf_core_t s);
		trl_word = {s.en_cap, `TRL_ONES, s.ind & s.en_cap, s.pad, s.ctx_vld, s.ctx_cnt};
	endfunction

	// ----------------------------------------------------------------
	// State and memory
	// ----------------------------------------------------------------
	vpf_pkg::vpf_core_t cur;
	vpf_pkg::vpf_core_t next_cur;
	logic               mem_we;
	logic [AW-1:0]      mem_waddr;
	logic [31:0]        mem_wdata;
	logic [31:0]        mem_q;

	vpf_block_ram #(
		.WIDTH (32),
		.DEPTH (DATA_WORDS)
	) vpf_block_ram_inst (
		.ref_clk_i (ref_clk_i),
		.we_i      (mem_we),
		.waddr_i   (mem_waddr),
		.wdata_i   (mem_wdata),
		.raddr_i   (cur.rd_addr[AW-1:0]),
		.rdata_o   (mem_q)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic        apb_wr;
		logic        can_load;
		logic        accept;
		logic [63:0] ext;
		logic [3:0]  fill;
		logic [2:0]  ev;
		apb_wr   = psel_i && penable_i && cur.apb.pready && pwrite_i;
		can_load = !cur.beat.valid || out_ready_i;
		accept   = cur.in_ready && in_valid_i;
		ext      = 64'(in_data_i);
		fill     = 4'({2'h0, cur.acc_bytes} + EB4);
		ev       = 3'h0;
		next_cur = cur;
		mem_we    = 1'b0;
		mem_waddr = cur.wr_addr[AW-1:0];
		mem_wdata = 32'h0000_0000;

		// Pins pass two flops before use
		next_cur.trig_m = trig_i;
		next_cur.trig_s = cur.trig_m;
		next_cur.cond_m = cond_i;
		next_cur.cond_s = cur.cond_m;

		if (cur.beat.valid && out_ready_i) begin
			next_cur.beat.valid = 1'b0;
			next_cur.beat.last  = 1'b0;
		end

		// APB: one wait-free access phase, answer prepared in setup
		next_cur.apb.pready  = 1'b0;
		next_cur.apb.pslverr = 1'b0;
		if (psel_i && !penable_i) begin
			next_cur.apb.pready = 1'b1;
			case (paddr_i)
				`OFS_CTRL:   next_cur.apb.prdata = 32'({cur.regs.tsf, cur.regs.tsi, 3'h0, cur.regs.en});
				`OFS_SID:    next_cur.apb.prdata = {cur.regs.dest, cur.regs.sid};
				`OFS_TRL_EN: next_cur.apb.prdata = 32'(cur.regs.trl_en);
				`OFS_CTX:    next_cur.apb.prdata = 32'({cur.regs.ctx_vld, cur.regs.ctx_cnt});
				`OFS_STATUS: next_cur.apb.prdata = 32'(cur.regs.status);
				`OFS_MASK:   next_cur.apb.prdata = 32'(cur.regs.mask);
				`OFS_INFO:   next_cur.apb.prdata = 32'({cur.last_pad, cur.pkt_cnt, 1'b0, cur.state});
				default: begin
					next_cur.apb.prdata  = 32'h0000_0000;
					next_cur.apb.pslverr = 1'b1;
				end
			endcase
		end
		if (apb_wr) begin
			case (paddr_i)
				`OFS_CTRL: begin
					next_cur.regs.en = pwdata_i[`CTRL_EN_BIT];
					// Code 0 for either field and fractional code 2 are refused; old value kept
					if (pwdata_i[`CTRL_TSI_LSB +: 2] != `TS_UNSUPPORTED) begin
						next_cur.regs.tsi = pwdata_i[`CTRL_TSI_LSB +: 2];
					end
					if (pwdata_i[`CTRL_TSF_LSB +: 2] != `TS_UNSUPPORTED && !pwdata_i[`CTRL_TSF_LSB]) begin
						next_cur.regs.tsf = cur.regs.tsf;
					end else if (pwdata_i[`CTRL_TSF_LSB +: 2] != `TS_UNSUPPORTED) begin
						next_cur.regs.tsf = pwdata_i[`CTRL_TSF_LSB +: 2];
					end
				end
				`OFS_SID: begin
					next_cur.regs.dest = pwdata_i[31:16];
					next_cur.regs.sid  = pwdata_i[15:0];
				end
				`OFS_TRL_EN: next_cur.regs.trl_en = pwdata_i[7:0];
				`OFS_CTX: begin
					next_cur.regs.ctx_vld = pwdata_i[`CTX_VLD_BIT];
					next_cur.regs.ctx_cnt = pwdata_i[6:0];
				end
				`OFS_STATUS: next_cur.regs.status = cur.regs.status & ~pwdata_i[`EV_BITS-1:0];
				`OFS_MASK:   next_cur.regs.mask = pwdata_i[`EV_BITS-1:0];
				default: ;
			endcase
		end

		// Packet sequencer
		case (cur.state)
			vpf_pkg::ST_IDLE: begin
				next_cur.rd_addr = 16'h0000;
				if (cur.regs.en && cur.trig_s) begin
					next_cur.state     = vpf_pkg::ST_FILL;
					next_cur.wr_addr   = 16'h0000;
					next_cur.nbytes    = 4'h0;
					next_cur.acc       = 32'h0000_0000;
					next_cur.acc_bytes = 2'h0;
					next_cur.ind       = 8'h00;
					next_cur.en_cap    = cur.regs.trl_en;
					next_cur.dest      = cur.regs.dest;
					next_cur.sid       = cur.regs.sid;
					next_cur.ctx_vld   = cur.regs.ctx_vld;
					next_cur.ctx_cnt   = cur.regs.ctx_cnt;
					next_cur.tsi       = cur.regs.tsi;
					next_cur.tsf       = cur.regs.tsf;
					next_cur.ts_int    = ts_int_i;
					next_cur.ts_frac   = ts_frac_i;
				end
			end
			vpf_pkg::ST_FILL: begin
				next_cur.ind = cur.ind | (cur.cond_s & cur.en_cap);
				if (cur.hi_pend) begin
					mem_we           = 1'b1;
					mem_wdata        = cur.hi_word;
					next_cur.hi_pend = 1'b0;
					next_cur.wr_addr = cur.wr_addr + 16'h0001;
				end else if (accept) begin
					next_cur.nbytes = cur.nbytes + EB4;
					if (EVENT_BITS == 64) begin
						mem_we           = 1'b1;
						mem_wdata        = ext[31:0];
						next_cur.hi_word = ext[63:32];
						next_cur.hi_pend = 1'b1;
						next_cur.wr_addr = cur.wr_addr + 16'h0001;
					end else if (fill >= `WORD_BYTES) begin
						mem_we             = 1'b1;
						mem_wdata          = cur.acc | (ext[31:0] << {cur.acc_bytes, 3'h0});
						next_cur.acc       = 32'h0000_0000;
						next_cur.acc_bytes = 2'h0;
						next_cur.wr_addr   = cur.wr_addr + 16'h0001;
					end else begin
						next_cur.acc       = cur.acc | (ext[31:0] << {cur.acc_bytes, 3'h0});
						next_cur.acc_bytes = fill[1:0];
					end
				end
				if (!next_cur.hi_pend && next_cur.wr_addr == DW16) begin
					next_cur.pad        = 4'h0;
					next_cur.data_words = DW16;
					next_cur.hdr_idx    = 3'h0;
					next_cur.state      = vpf_pkg::ST_HDR;
				end else if (!next_cur.hi_pend && !cur.trig_s) begin
					next_cur.state = vpf_pkg::ST_FLUSH;
				end
			end
			vpf_pkg::ST_FLUSH: begin
				next_cur.pad   = 4'(4'h0 - cur.nbytes);
				next_cur.state = vpf_pkg::ST_PAD;
				if (cur.acc_bytes != 2'h0) begin
					mem_we             = 1'b1;
					mem_wdata          = cur.acc;
					next_cur.acc       = 32'h0000_0000;
					next_cur.acc_bytes = 2'h0;
					next_cur.wr_addr   = cur.wr_addr + 16'h0001;
				end else if (cur.wr_addr == 16'h0000) begin
					// Nothing gathered: an empty packet would carry no data
					ev[`EV_DROPPED] = 1'b1;
					next_cur.state  = vpf_pkg::ST_IDLE;
				end
			end
			vpf_pkg::ST_PAD: begin
				if ((cur.wr_addr & `BLK_MASK) != 16'h0000) begin
					mem_we           = 1'b1;
					mem_wdata        = 32'h0000_0000;
					next_cur.wr_addr = cur.wr_addr + 16'h0001;
				end else begin
					next_cur.data_words = cur.wr_addr;
					next_cur.hdr_idx    = 3'h0;
					next_cur.state      = vpf_pkg::ST_HDR;
				end
			end
			vpf_pkg::ST_HDR: begin
				if (can_load) begin
					next_cur.beat.data  = hdr_word(cur.hdr_idx, cur);
					next_cur.beat.valid = 1'b1;
					next_cur.beat.last  = 1'b0;
					next_cur.hdr_idx    = cur.hdr_idx + 3'h1;
					if (cur.hdr_idx == `HDR_LAST_IDX) begin
						next_cur.q_ok  = 1'b0;
						next_cur.state = vpf_pkg::ST_DATA;
					end
				end
			end
			vpf_pkg::ST_DATA: begin
				// Read data lag one cycle behind the address; half rate is the price
				if (!cur.q_ok) begin
					next_cur.q_ok = 1'b1;
				end else if (can_load) begin
					next_cur.beat.data  = mem_q;
					next_cur.beat.valid = 1'b1;
					next_cur.beat.last  = 1'b0;
					next_cur.q_ok       = 1'b0;
					next_cur.rd_addr    = cur.rd_addr + 16'h0001;
					if (cur.rd_addr + 16'h0001 == cur.data_words) begin
						next_cur.state = vpf_pkg::ST_TRL;
					end
				end
			end
			vpf_pkg::ST_TRL: begin
				if (can_load) begin
					next_cur.beat.data  = trl_word(cur);
					next_cur.beat.valid = 1'b1;
					next_cur.beat.last  = 1'b1;
					next_cur.pkt_cnt    = cur.pkt_cnt + 4'h1;
					next_cur.last_pad   = cur.pad;
					ev[`EV_SENT]        = 1'b1;
					ev[`EV_PADDED]      = (cur.pad != 4'h0);
					next_cur.state      = vpf_pkg::ST_IDLE;
				end
			end
			default: next_cur.state = vpf_pkg::ST_IDLE;
		endcase

		mem_waddr = cur.wr_addr[AW-1:0];
		next_cur.in_ready = (next_cur.state == vpf_pkg::ST_FILL) && !next_cur.hi_pend;
		// Set wins over a clear in the same cycle
		next_cur.regs.status = next_cur.regs.status | ev;
		next_cur.irq = |(next_cur.regs.status & next_cur.regs.mask);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			cur          <= '0;
			cur.regs.tsi <= `TSI_RST;
			cur.regs.tsf <= `TSF_RST;
		end else begin
			cur <= next_cur;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata_o    = cur.apb.prdata;
	assign pready_o    = cur.apb.pready;
	assign pslverr_o   = cur.apb.pslverr;
	assign in_ready_o  = cur.in_ready;
	assign out_data_o  = cur.beat.data;
	assign out_last_o  = cur.beat.last;
	assign out_valid_o = cur.beat.valid;
	assign dest_o      = cur.dest;
	assign irq_o       = cur.irq;

endmodule

// ==== testbench/vpf_properties.sv ====
// Concurrent checks on the framed output stream
`timescale 1ns/1ps
module vpf_properties #(
	parameter int EVENT_BITS = 32
) (
	input  wire logic        ref_clk_i,
	input  wire logic        srst_i,
	input  wire logic [31:0] out_data_o,
	input  wire logic        out_last_o,
	input  wire logic        out_valid_o,
	input  wire logic        out_ready_i,
	input  wire logic [15:0] dest_o
);
	// ----------------------------------------------------------------
	// Beat tracking
	// ----------------------------------------------------------------
	// Ceiling follows event width: wider events leave fewer bytes open
	localparam logic [3:0] MAX_PAD = (EVENT_BITS == 16) ? 4'hE : (EVENT_BITS == 32) ? 4'hC : 4'h8;
	logic [15:0] beat;
	logic [15:0] size;
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			beat <= 16'h0000;
			size <= 16'h0000;
		end else if (out_valid_o && out_ready_i) begin
			beat <= out_last_o ? 16'h0000 : beat + 16'h0001;
			if (beat == 16'h0000) begin
				size <= out_data_o[15:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);

	a_hdr_type_flags: assert property (out_valid_o && beat == 16'h0000 |-> out_data_o[31:24] == 8'h1C)
		else $error("header word type or flags wrong");
	a_size_whole_blocks: assert property (out_valid_o && beat == 16'h0000 |-> out_data_o[1:0] == 2'h0)
		else $error("packet size not a multiple of four");
	a_word_count: assert property (out_valid_o && out_ready_i && out_last_o |-> beat + 16'h0001 == size)
		else $error("beat count differs from header size");
	a_sid_dest_mask: assert property (out_valid_o && beat == 16'h0001 |-> out_data_o[31:16] == dest_o)
		else $error("second word upper half not the routing mask");
	a_class_reserved: assert property (out_valid_o && (beat == 16'h0002 || beat == 16'h0003) |-> out_data_o == 32'h0)
		else $error("class word not zero");
	a_beat_hold: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o) && $stable(out_last_o))
		else $error("beat changed while stalled");
	a_trl_ones: assert property (out_valid_o && out_last_o |-> out_data_o[23:20] == 4'hF)
		else $error("trailer fixed ones missing");
	a_ind_gated: assert property (out_valid_o && out_last_o |-> (out_data_o[19:12] & ~out_data_o[31:24]) == 8'h00)
		else $error("indicator set without its enable");
	a_pad_ceiling: assert property (out_valid_o && out_last_o |-> out_data_o[11:8] <= MAX_PAD)
		else $error("pad count above ceiling");
endmodule

bind vita_packet_trailer_framer vpf_properties #(.EVENT_BITS(EVENT_BITS)) vpf_properties_inst (
	.ref_clk_i  (ref_clk_i),
	.srst_i     (srst_i),
	.out_data_o (out_data_o),
	.out_last_o (out_last_o),
	.out_valid_o(out_valid_o),
	.out_ready_i(out_ready_i),
	.dest_o     (dest_o)
);

// ==== testbench/vpf_route_sink.sv ====
// Routing-stage model that takes framed beats, stalling on request
`timescale 1ns/1ps
module vpf_route_sink (
	input  wire logic        ref_clk_i,
	input  wire logic        srst_i,
	input  wire logic        stall_i,
	input  wire logic [31:0] data_i,
	input  wire logic        last_i,
	input  wire logic        valid_i,
	output logic             ready_o
);
	logic [31:0] words [$];
	logic        lasts [$];
	logic        phase;
	// Stall halves the accept rate so held beats are seen
	assign ready_o = !srst_i && (!stall_i || phase);
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			phase <= 1'b0;
		end else begin
			phase <= ~phase;
			if (valid_i && ready_o) begin
				words.push_back(data_i);
				lasts.push_back(last_i);
			end
		end
	end
endmodule

// ==== testbench/vita_packet_trailer_framer_bench.sv ====
// Self-checking bench of the packet trailer framer
`timescale 1ns/1ps
module vita_packet_trailer_framer_bench;
	localparam logic [31:0] TS_INT  = 32'h1234_5678;
	localparam logic [63:0] TS_FRAC = 64'h0BAD_F00D_2468_ACE0;
	logic        ref_clk_i, srst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, trig_i, stall;
	logic        in_valid_i, in_ready_o, out_last_o, out_valid_o, out_ready_i, irq_o;
	logic [7:0]  paddr_i, cond_i;
	logic [15:0] dest_o;
	logic [31:0] pwdata_i, prdata_o, in_data_i, out_data_o, rd;
	logic [31:0] w [$];
	int          n_mismatch = 0;
	int          tests_run = 0;

	vita_packet_trailer_framer #(.EVENT_BITS(32), .DATA_WORDS(8)) vita_packet_trailer_framer_inst (
		.ref_clk_i(ref_clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .trig_i(trig_i), .cond_i(cond_i),
		.ts_int_i(TS_INT), .ts_frac_i(TS_FRAC), .in_data_i(in_data_i), .in_valid_i(in_valid_i),
		.in_ready_o(in_ready_o), .out_data_o(out_data_o), .out_last_o(out_last_o),
		.out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .dest_o(dest_o), .irq_o(irq_o));
	vpf_route_sink vpf_route_sink_inst (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .stall_i(stall),
		.data_i(out_data_o), .last_i(out_last_o), .valid_i(out_valid_o), .ready_o(out_ready_i));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("Counts: %0d compares, %0d mismatches", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic hang();
		n_mismatch++;
		$display("BAD t=%0t wait ran out", $time);
		conclude();
	endtask

	// One idle edge at the end so a following setup never collides
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge ref_clk_i);
		penable_i <= 1'b1;
		for (int i = 0; i <= 20; i++) begin
			@(posedge ref_clk_i);
			if (pready_o === 1'b1) begin
				rd = wr ? 32'h0 : prdata_o;
				rd[0] = wr ? pslverr_o : rd[0];
				break;
			end
			if (i == 20) hang();
		end
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask

	task automatic send(input int n, input logic [31:0] base);
		for (int k = 0; k < n; k++) begin
			in_valid_i <= 1'b1;
			in_data_i <= base + 32'(k);
			for (int i = 0; i <= 60; i++) begin
				@(posedge ref_clk_i);
				if (in_ready_o === 1'b1) break;
				if (i == 60) hang();
			end
		end
		in_valid_i <= 1'b0;
	endtask

	task automatic pkt(input int nd, input int nv, input logic [3:0] cnt, input logic [31:0] trl, input logic [31:0] base);
		for (int i = 0; vpf_route_sink_inst.words.size() < nd + 8; i++) begin
			@(posedge ref_clk_i);
			if (i == 3000) hang();
		end
		w = vpf_route_sink_inst.words;
		chk(w[0], {8'h1C, 4'h5, cnt, 16'(nd + 8)});
		chk(w[1], 32'hA5A5_1234);
		chk(w[2] | w[3], 32'h0);
		chk(w[4], TS_INT);
		chk(w[5], TS_FRAC[63:32]);
		chk(w[6], TS_FRAC[31:0]);
		for (int k = 0; k < nd; k++) begin
			chk(w[7 + k], (k < nv) ? base + 32'(k) : 32'h0);
		end
		chk(w[nd + 7], trl);
		chk({31'h0, vpf_route_sink_inst.lasts[nd + 6]}, 32'h0);
		chk({31'h0, vpf_route_sink_inst.lasts[nd + 7]}, 32'h1);
		chk({16'h0, dest_o}, 32'h0000_A5A5);
		vpf_route_sink_inst.words.delete();
		vpf_route_sink_inst.lasts.delete();
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_regs();
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0000_0050);
		apb(1'b1, 8'h00, 32'h0000_00E0);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0000_00E0);
		// Unsupported timestamp codes keep the old formats
		apb(1'b1, 8'h00, 32'h0000_0080);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0000_00E0);
		apb(1'b0, 8'h1C, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
		chk(rd, 32'h1);
		$display("test_regs done");
	endtask

	// Full block, conditions pulsed early: only enabled ones stick
	task automatic test_full();
		apb(1'b1, 8'h04, 32'hA5A5_1234);
		apb(1'b1, 8'h08, 32'h0000_00F0);
		apb(1'b1, 8'h0C, 32'h0000_0085);
		apb(1'b1, 8'h14, 32'h0000_0001);
		apb(1'b1, 8'h00, 32'h0000_0051);
		trig_i <= 1'b1;
		cond_i <= 8'hA5;
		fork
			begin
				repeat (8) @(posedge ref_clk_i);
				cond_i <= 8'h00;
			end
		join_none
		send(8, 32'h1000_0000);
		trig_i <= 1'b0;
		pkt(8, 8, 4'h0, 32'hF0FA_0085, 32'h1000_0000);
		chk({31'h0, irq_o}, 32'h1);
		apb(1'b1, 8'h14, 32'h0);
		repeat (2) @(posedge ref_clk_i);
		chk({31'h0, irq_o}, 32'h0);
		apb(1'b1, 8'h10, 32'h0000_0007);
		apb(1'b1, 8'h14, 32'h0000_0001);
		repeat (2) @(posedge ref_clk_i);
		chk({31'h0, irq_o}, 32'h0);
		$display("test_full done");
	endtask

	// Trigger ends after 12 bytes: four pad bytes, sink stalling
	task automatic test_pad();
		stall <= 1'b1;
		trig_i <= 1'b1;
		send(3, 32'h2000_0000);
		trig_i <= 1'b0;
		pkt(4, 3, 4'h1, 32'hF0F0_0485, 32'h2000_0000);
		$display("test_pad done");
	endtask

	// Trigger pulse with nothing gathered, then a reset in mid-run
	task automatic test_drop();
		trig_i <= 1'b1;
		repeat (6) @(posedge ref_clk_i);
		trig_i <= 1'b0;
		repeat (6) @(posedge ref_clk_i);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0000_0007);
		apb(1'b0, 8'h18, 32'h0);
		chk(rd, 32'h0000_0420);
		srst_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		@(posedge ref_clk_i);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0000_0050);
		$display("test_drop done");
	endtask

	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	initial begin
		{srst_i, psel_i, penable_i, pwrite_i, trig_i, in_valid_i, stall} = 7'h41;
		stall = 1'b0;
		paddr_i = 8'h00;
		pwdata_i = 32'h0;
		in_data_i = 32'h0;
		cond_i = 8'h00;
		repeat (10) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		@(posedge ref_clk_i);
		test_regs();
		test_full();
		test_pad();
		test_drop();
		conclude();
	end
endmodule
